// ==== hdl/ccse_pkg.sv ====
/*
  Constants shared by the charge-state status encoder: AHB register map, field
  positions, reset values, status encodings and timing counts.
  Assumes a 100 MHz hclk.
*/
`default_nettype none
package ccse_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SLOW_PERIOD_MS = 1000;
  localparam int FAST_PERIOD_US = 40;
  localparam int SLOW_PERIOD_CYC = (CLK_HZ / 1000) * SLOW_PERIOD_MS;
  localparam int FAST_PERIOD_CYC = (CLK_HZ / 1_000_000) * FAST_PERIOD_US;
  localparam int PERIODS_PER_WORD = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] SENSE_OFS = 8'h08;

  // control fields
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int CTRL_BOOST_CLR_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status fields
  localparam int ST_PHASE_LSB = 0;
  localparam int ST_FAST_BIT = 4;
  localparam int ST_BOOST_BIT = 5;
  localparam int ST_PASS_BIT = 6;
  localparam int ST_NIBBLE_LSB = 8;

  // ----------------------------------------------------------------
  // charger phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCSE_SLEEP = 3'b000,
    CCSE_PRECOND = 3'b001,
    CCSE_CONST_CUR = 3'b010,
    CCSE_CONST_VOLT = 3'b011,
    CCSE_FAULT = 3'b100,
    CCSE_INHIBIT = 3'b101
  } ccse_phase_t;

  // sink pattern, bit 3 = first period, 1 = sink on (LED on / line low)
  localparam logic [3:0] PAT_SLEEP = 4'h0;
  localparam logic [3:0] PAT_FAULT = 4'hC;
  localparam logic [3:0] PAT_COND = 4'hF;
  localparam logic [3:0] PAT_CC = 4'hE;
  localparam logic [3:0] PAT_CV = 4'h8;
  localparam logic [3:0] PAT_NOBAT = 4'hC;
endpackage : ccse_pkg
`default_nettype wire

// ==== hdl/ccse_top.sv ====
/*
  Charge cycle sequencer and open-drain status word encoder for a single-cell
  linear charger, with an AHB-Lite register slave.
  Assumes comparator results arrive synchronous to hclk, hresetn is the
  power-on reset, and one AHB-Lite master drives single word transfers.
*/
`default_nettype none
module ccse_top
  import ccse_pkg::*;
#(
  parameter int SLOW_CYC = SLOW_PERIOD_CYC, // slow status period in hclk cycles
  parameter int FAST_CYC = FAST_PERIOD_CYC  // fast status period in hclk cycles
) (
  input wire logic hclk,             // 100 MHz clock
  input wire logic hresetn,          // async power-on reset, active low
  input wire logic hsel,             // slave select
  input wire logic [31:0] haddr,     // byte address
  input wire logic [1:0] htrans,     // transfer type
  input wire logic hwrite,           // write when high
  input wire logic [2:0] hsize,      // transfer size
  input wire logic [31:0] hwdata,    // write data
  input wire logic hready,           // bus ready in
  output logic hreadyout,            // always ready
  output logic hresp,                // always OKAY
  output logic [31:0] hrdata,        // read data
  input wire logic supply_ok,        // input above lockout level
  input wire logic bat_present,      // battery detected on cell terminal
  input wire logic temp_in_window,   // thermal_sense_input inside window
  input wire logic temp_low,         // thermal_sense_input pulled low
  input wire logic over_temp,        // cell over-temperature sensed
  input wire logic overcurrent_fault,        // charge over-current sensed
  input wire logic excess_cell_voltage_fault, // cell above max voltage
  input wire logic below_precond,    // cell below precondition threshold
  input wire logic at_regulation,    // cell reached regulation_voltage
  input wire logic below_recharge,   // cell below recharge_threshold (hysteretic)
  input wire logic term_current,     // charge current at termination level
  input wire logic trickle_boost_strap, // strap level
  output logic pass_on,              // pass device enable
  output logic trickle_2x,           // doubled trickle selected
  output logic status_o,             // status pin output value (always 0)
  output logic status_oe             // status pin sink enable
);
  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  // read once per power-up; later strap moves only change the trickle level
  logic strap_done_reg;
  logic fast_mode_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_reg <= 1'b0;
      fast_mode_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      fast_mode_reg <= trickle_boost_strap;
    end
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_ctrl = wr_pend_reg && (addr_reg == CTRL_OFS);
  wire sw_inhibit = ctrl_reg[CTRL_INHIBIT_BIT];
  wire boost_clr_pulse = wr_ctrl && hwdata[CTRL_BOOST_CLR_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      ctrl_reg <= CTRL_RESET;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        addr_reg <= haddr[7:0];
      end
      if (wr_ctrl) begin
        ctrl_reg <= {31'h0000_0000, hwdata[CTRL_INHIBIT_BIT]};
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // charge sequencer
  // ----------------------------------------------------------------
  ccse_phase_t phase_reg, phase_next;
  logic boost_ok_reg;
  logic ot_seen_reg;
  logic temp_low_reg;

  wire any_fault = overcurrent_fault || excess_cell_voltage_fault || over_temp;
  wire temp_bad = !temp_in_window || sw_inhibit;

  // pick the phase that matches the cell voltage
  function automatic ccse_phase_t entry_phase(input logic pre, input logic reg_v);
    if (pre) begin
      entry_phase = CCSE_PRECOND;
    end else if (reg_v) begin
      entry_phase = CCSE_CONST_VOLT;
    end else begin
      entry_phase = CCSE_CONST_CUR;
    end
  endfunction : entry_phase

  wire ccse_phase_t resume_phase = entry_phase(below_precond, at_regulation);

  always_comb begin
    phase_next = phase_reg;
    if (!supply_ok) begin
      // active phase is kept so the cycle carries on where it stopped
      phase_next = phase_reg;
    end else begin
      unique case (phase_reg)
        CCSE_SLEEP: begin
          if (any_fault) begin
            phase_next = CCSE_FAULT;
          end else if (bat_present && below_recharge) begin
            phase_next = temp_bad ? CCSE_INHIBIT : resume_phase;
          end
        end
        CCSE_INHIBIT: begin
          if (any_fault) begin
            phase_next = CCSE_FAULT;
          end else if (!temp_bad) begin
            phase_next = resume_phase;
          end
        end
        CCSE_FAULT: begin
          if (!any_fault) begin
            // after over-temperature, restart in trickle
            phase_next = ot_seen_reg ? CCSE_PRECOND : resume_phase;
          end
        end
        CCSE_PRECOND, CCSE_CONST_CUR, CCSE_CONST_VOLT: begin
          if (any_fault) begin
            phase_next = CCSE_FAULT;
          end else if (temp_bad) begin
            phase_next = CCSE_INHIBIT;
          end else if (!bat_present) begin
            phase_next = CCSE_SLEEP;
          end else if (phase_reg == CCSE_PRECOND && !below_precond) begin
            phase_next = CCSE_CONST_CUR;
          end else if (phase_reg == CCSE_CONST_CUR && at_regulation) begin
            phase_next = CCSE_CONST_VOLT;
          end else if (phase_reg == CCSE_CONST_VOLT && term_current) begin
            phase_next = CCSE_SLEEP;
          end
        end
        default: phase_next = CCSE_SLEEP;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= CCSE_SLEEP;
      boost_ok_reg <= 1'b1;
      ot_seen_reg <= 1'b0;
      temp_low_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      temp_low_reg <= temp_low;
      // over-temp, a low pulse on the thermal input, or software drops 2X
      if (over_temp || (temp_low && !temp_low_reg) || boost_clr_pulse) begin
        boost_ok_reg <= 1'b0;
      end
      if (over_temp) begin
        ot_seen_reg <= 1'b1;
      end else if (phase_reg == CCSE_PRECOND && !below_precond) begin
        ot_seen_reg <= 1'b0;
      end
    end
  end

  wire charging = (phase_reg == CCSE_PRECOND) || (phase_reg == CCSE_CONST_CUR)
    || (phase_reg == CCSE_CONST_VOLT);
  assign pass_on = charging && supply_ok && !any_fault && !temp_bad;
  // strap high selects doubled trickle, in fast mode too
  assign trickle_2x = trickle_boost_strap && boost_ok_reg && !ot_seen_reg;

  // ----------------------------------------------------------------
  // status word encoder
  // ----------------------------------------------------------------
  logic [31:0] per_cnt_reg;
  logic [1:0] slot_reg;
  logic [3:0] word_reg;

  function automatic logic [3:0] phase_pattern(input ccse_phase_t p, input logic cell_terminal);
    unique case (p)
      CCSE_FAULT: phase_pattern = PAT_FAULT;
      CCSE_PRECOND: phase_pattern = PAT_COND;
      CCSE_CONST_CUR: phase_pattern = PAT_CC;
      CCSE_CONST_VOLT: phase_pattern = PAT_CV;
      default: phase_pattern = cell_terminal ? PAT_SLEEP : PAT_NOBAT;
    endcase
  endfunction : phase_pattern

  // counter wraps each period, so words follow back to back with no gap
  wire [31:0] per_len = fast_mode_reg ? 32'(FAST_CYC) : 32'(SLOW_CYC);
  wire per_end = (per_cnt_reg == per_len - 32'h0000_0001);
  wire word_end = per_end && (slot_reg == 2'(PERIODS_PER_WORD - 1));
  wire [3:0] next_word = phase_pattern(phase_next, bat_present);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt_reg <= 32'h0000_0000;
      slot_reg <= 2'b00;
      word_reg <= PAT_SLEEP;
    end else begin
      per_cnt_reg <= per_end ? 32'h0000_0000 : per_cnt_reg + 32'h0000_0001;
      if (per_end) begin
        slot_reg <= slot_reg + 2'b01;
      end
      if (word_end) begin
        word_reg <= next_word;
      end
    end
  end

  // sink on equals line low; fast mode levels are the same sink pattern
  assign status_o = 1'b0;
  assign status_oe = word_reg[2'd3 - slot_reg];

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // captured at the address phase so hrdata comes from a flop; a control
  // write still in its data phase is forwarded so a back-to-back read sees it
  logic [31:0] hrdata_reg;
  wire rd_phase = addr_phase && !hwrite;
  wire [31:0] ctrl_view = wr_ctrl ? {31'h0000_0000, hwdata[CTRL_INHIBIT_BIT]} : ctrl_reg;
  wire [31:0] status_word = {20'h0_0000, word_reg, 1'b0, pass_on, trickle_2x,
    fast_mode_reg, 1'b0, phase_reg};
  wire [31:0] sense_word = {22'h00_0000, term_current, below_recharge, at_regulation,
    below_precond, excess_cell_voltage_fault, overcurrent_fault, over_temp,
    temp_in_window, bat_present, supply_ok};
  wire [31:0] rd_mux = (haddr[7:0] == CTRL_OFS) ? ctrl_view :
                       (haddr[7:0] == STATUS_OFS) ? status_word :
                       (haddr[7:0] == SENSE_OFS) ? sense_word : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_phase) begin
      hrdata_reg <= rd_mux;
    end
  end

  assign hrdata = hrdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pass_off_fault: assert property (any_fault |-> !pass_on)
    else $error("pass device on during fault");
  a_cv_terminate: assert property (
    (phase_reg == CCSE_CONST_VOLT && term_current && supply_ok && !any_fault
     && !temp_bad && bat_present) |=> phase_reg == CCSE_SLEEP)
    else $error("cycle did not terminate into sleep");
  a_sleep_hold: assert property (
    (phase_reg == CCSE_SLEEP && !below_recharge && !any_fault) |=> phase_reg == CCSE_SLEEP)
    else $error("left sleep above recharge threshold");
  a_inhibit_off: assert property (temp_bad |-> !pass_on)
    else $error("pass on while thermal input out of window");
  a_supply_off: assert property (!supply_ok |-> !pass_on)
    else $error("pass on without supply");
  a_supply_keep: assert property (!supply_ok |=> phase_reg == $past(phase_reg))
    else $error("phase lost during supply loss");
  a_precond_to_cc: assert property (
    (phase_reg == CCSE_PRECOND && !below_precond && supply_ok && !any_fault && !temp_bad
     && bat_present) |=> phase_reg == CCSE_CONST_CUR)
    else $error("no move from trickle to constant current");
  a_ot_boost_off: assert property (over_temp |=> !trickle_2x)
    else $error("doubled trickle kept after over-temperature");
  a_word_steady: assert property (!word_end |=> $stable(word_reg))
    else $error("status word changed inside a word");
  a_fault_clear: assert property (
    (phase_reg == CCSE_FAULT && !any_fault && ot_seen_reg && supply_ok)
    |=> phase_reg == CCSE_PRECOND)
    else $error("no trickle restart after over-temperature");

  // further sequencer moves and the pass device gate
  a_fault_entry: assert property (
    (supply_ok && any_fault && phase_reg != CCSE_FAULT) |=> phase_reg == CCSE_FAULT)
    else $error("fault status not entered");
  a_fault_hold: assert property (
    (phase_reg == CCSE_FAULT && any_fault) |=> phase_reg == CCSE_FAULT)
    else $error("fault left while a fault is still sensed");
  a_inhibit_entry: assert property (
    (supply_ok && !any_fault && temp_bad && charging) |=> phase_reg == CCSE_INHIBIT)
    else $error("charging kept with thermal input out of window");
  a_sleep_wake: assert property (
    (phase_reg == CCSE_SLEEP && supply_ok && !any_fault && bat_present && below_recharge)
    |=> phase_reg != CCSE_SLEEP)
    else $error("sleep kept below recharge threshold");
  a_nobat_sleep: assert property (
    (supply_ok && !any_fault && !temp_bad && !bat_present && charging)
    |=> phase_reg == CCSE_SLEEP)
    else $error("charging kept with no battery");
  a_cc_to_cv: assert property (
    (phase_reg == CCSE_CONST_CUR && at_regulation && supply_ok && !any_fault && !temp_bad
     && bat_present) |=> phase_reg == CCSE_CONST_VOLT)
    else $error("no move from constant current to constant voltage");
  a_pass_charging: assert property (pass_on |-> charging)
    else $error("pass device on outside a charge phase");

  // status word timing
  a_period_len: assert property (per_cnt_reg < per_len)
    else $error("period counter ran past its length");
  a_slot_step: assert property (per_end |=> slot_reg == $past(slot_reg) + 2'b01)
    else $error("slot did not advance at period end");
  a_word_sample: assert property (word_end |=> word_reg == $past(next_word))
    else $error("status word not taken at word end");
  a_strap_hold: assert property (strap_done_reg |=> $stable(fast_mode_reg))
    else $error("reporting rate changed after power-up");
  a_fault_word: assert property (
    (word_end && phase_next == CCSE_FAULT) |=> word_reg == PAT_FAULT)
    else $error("fault word not sent");
  a_sleep_word: assert property (
    (word_end && phase_next == CCSE_SLEEP && bat_present) |=> word_reg == PAT_SLEEP)
    else $error("sleep word not sent");
  a_nobat_word: assert property (
    (word_end && phase_next == CCSE_SLEEP && !bat_present) |=> word_reg == PAT_NOBAT)
    else $error("no battery word not sent");

  // trickle level
  a_boost_ot: assert property (ot_seen_reg |-> !trickle_2x)
    else $error("doubled trickle during restart after over-temperature");
  a_boost_pulse: assert property ((temp_low && !temp_low_reg) |=> !trickle_2x)
    else $error("doubled trickle kept after thermal input low pulse");

  c_full_cycle: cover property (phase_reg == CCSE_CONST_VOLT ##1 phase_reg == CCSE_SLEEP);
  c_fault_seen: cover property (phase_reg == CCSE_FAULT ##1 phase_reg == CCSE_PRECOND);
  c_inhibit: cover property (phase_reg == CCSE_INHIBIT);
  c_word_end: cover property (word_end && word_reg == PAT_CC);
  c_fast_word: cover property (fast_mode_reg && word_end && word_reg == PAT_CV);
endmodule : ccse_top
`default_nettype wire

// ==== sim/ccse_status_reader.sv ====
/*
  Far-side model of the status line: a microcontroller input behind a pull-up.
  Assumes the encoder only ever sinks the line and never drives it high.
*/
`default_nettype none
module ccse_status_reader (
  input wire logic status_o,  // value driven while sinking
  input wire logic status_oe, // sink enable from the encoder
  output logic line_level     // level seen by the reader
);
  timeunit 1ns;
  timeprecision 1ps;
  // pure high-impedance reader, no indicator load on the line
  // released line floats up to the pull-up level
  assign line_level = status_oe ? status_o : 1'b1;
endmodule : ccse_status_reader
`default_nettype wire

// ==== sim/ccse_top_bench.sv ====
/*
  Self-checking bench for ccse_top: register bus tasks, random and directed
  sense stimulus, status word decoding. Assumes shortened period counts.
*/
`default_nettype none
module ccse_top_bench;
  import ccse_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int SP = 20;
  localparam int FP = 8;
  localparam int I_SUP = 0, I_PRES = 1, I_TWIN = 2, I_OT = 3, I_OCUR = 4, I_OVOLT = 5;
  localparam int I_PRE = 6, I_REGV = 7, I_RCH = 8, I_TERM = 9;
  localparam logic [9:0] GOOD = 10'h147;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, temp_low = 1'b0, strap = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, d;
  logic [9:0] sense = 10'h000;
  logic hreadyout, hresp, pass_on, trickle_2x, status_o, status_oe, line_level;
  logic [31:0] hrdata;
  int cyc, bad_count, cmp_count;
  always #5 hclk = ~hclk;
  always_ff @(posedge hclk or negedge hresetn) if (!hresetn) cyc <= 0; else cyc <= cyc + 1;
  ccse_top #(.SLOW_CYC(SP), .FAST_CYC(FP)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .supply_ok(sense[I_SUP]), .bat_present(sense[I_PRES]),
    .temp_in_window(sense[I_TWIN]), .temp_low(temp_low), .over_temp(sense[I_OT]),
    .overcurrent_fault(sense[I_OCUR]), .excess_cell_voltage_fault(sense[I_OVOLT]),
    .below_precond(sense[I_PRE]), .at_regulation(sense[I_REGV]),
    .below_recharge(sense[I_RCH]), .term_current(sense[I_TERM]),
    .trickle_boost_strap(strap), .pass_on(pass_on), .trickle_2x(trickle_2x),
    .status_o(status_o), .status_oe(status_oe));
  ccse_status_reader reader (.status_o(status_o), .status_oe(status_oe),
    .line_level(line_level));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic put(input int i, input logic v);
    @(posedge hclk);
    sense[i] <= v;
    repeat (3) @(posedge hclk);
    #1;
  endtask : put
  task automatic chk_phase(input logic [2:0] ph, input logic pass);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk({29'h0, rd[2:0]}, {29'h0, ph}, "phase");
    chk({31'h0, pass_on}, {31'h0, pass}, "pass device");
  endtask : chk_phase
  // second captured word is the first one wholly after the input change
  task automatic chk_word(input int p, input logic [3:0] exp);
    logic [3:0] w;
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk);
      while (cyc % (4 * p) != p / 2) @(posedge hclk);
      for (int i = 3; i >= 0; i--) begin
        w[i] = ~line_level;
        if (i > 0) repeat (p) @(posedge hclk);
      end
    end
    chk({28'h0, w}, {28'h0, exp}, "status word");
  endtask : chk_word
  task automatic restart(input logic s);
    @(posedge hclk);
    hresetn <= 1'b0;
    strap <= s;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    sense <= GOOD;
    repeat (3) @(posedge hclk);
    #1;
  endtask : restart
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // about 2000 cycles of tests; 40000 leaves ample room
  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(32'h2cd2c844));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "ctrl reset");
    bus(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped read");
    for (int k = 0; k < 8; k++) begin
      @(posedge hclk);
      sense <= 10'($urandom());
      d = $urandom();
      bus(1'b1, 32'h0000_0000, d);
      bus(1'b0, 32'h0000_0000, 32'h0000_0000);
      chk(rd, {31'h0, d[0]}, "ctrl readback");
      bus(1'b0, 32'h0000_0008, 32'h0000_0000);
      chk(rd, {22'h0, sense}, "sense readback");
    end
    // random sense may leave any phase behind: start the sequence from power-up
    restart(1'b0);
    strap <= 1'b1;
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk({31'h0, rd[4]}, 32'h0000_0000, "strap after power-up");
    @(posedge hclk);
    sense <= GOOD;
    chk_phase(3'h1, 1'b1);
    chk_word(SP, 4'hF);
    put(I_PRE, 1'b0);
    chk_phase(3'h2, 1'b1);
    chk_word(SP, 4'hE);
    put(I_REGV, 1'b1);
    chk_word(SP, 4'h8);
    put(I_SUP, 1'b0);
    chk_phase(3'h3, 1'b0);
    put(I_SUP, 1'b1);
    chk_phase(3'h3, 1'b1);
    put(I_RCH, 1'b0);
    put(I_TERM, 1'b1);
    chk_phase(3'h0, 1'b0);
    chk_word(SP, 4'h0);
    put(I_TERM, 1'b0);
    put(I_REGV, 1'b0);
    chk_phase(3'h0, 1'b0);
    put(I_RCH, 1'b1);
    chk_phase(3'h2, 1'b1);
    put(I_OCUR, 1'b1);
    chk_phase(3'h4, 1'b0);
    chk_word(SP, 4'hC);
    put(I_OCUR, 1'b0);
    chk_phase(3'h2, 1'b1);
    put(I_OVOLT, 1'b1);
    chk_phase(3'h4, 1'b0);
    put(I_OVOLT, 1'b0);
    chk_phase(3'h2, 1'b1);
    put(I_TWIN, 1'b0);
    chk_phase(3'h5, 1'b0);
    put(I_TWIN, 1'b1);
    bus(1'b1, 32'h0000_0000, 32'h0000_0001);
    chk_phase(3'h5, 1'b0);
    bus(1'b1, 32'h0000_0000, 32'h0000_0000);
    put(I_PRES, 1'b0);
    chk_word(SP, 4'hC);
    chk_phase(3'h0, 1'b0);
    restart(1'b1);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk({31'h0, rd[4]}, 32'h0000_0001, "fast mode");
    chk({31'h0, trickle_2x}, 32'h0000_0001, "doubled trickle");
    chk_word(FP, 4'hF);
    put(I_PRE, 1'b0);
    chk_word(FP, 4'hE);
    put(I_REGV, 1'b1);
    chk_word(FP, 4'h8);
    put(I_OT, 1'b1);
    chk_word(FP, 4'hC);
    put(I_PRE, 1'b1);
    put(I_REGV, 1'b0);
    put(I_OT, 1'b0);
    chk_phase(3'h1, 1'b1);
    chk({31'h0, trickle_2x}, 32'h0000_0000, "trickle after fault");
    restart(1'b1);
    @(posedge hclk);
    temp_low <= 1'b1;
    @(posedge hclk);
    temp_low <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk({31'h0, trickle_2x}, 32'h0000_0000, "trickle after low pulse");
    put(I_RCH, 1'b0);
    put(I_PRE, 1'b0);
    put(I_REGV, 1'b1);
    put(I_TERM, 1'b1);
    chk_word(FP, 4'h0);
    results();
  end
endmodule : ccse_top_bench
`default_nettype wire
